// ===== pkg/edo_ctrl_pkg.sv
// Constants and carrier types for the extended-data-out DRAM controller
package edo_ctrl_pkg;
   localparam int  CLK_HZ         = 20_000_000;
   localparam int  ROW_W          = 12;
   localparam int  COL_W          = 10;
   localparam int  DATA_W         = 4;
   localparam int  ADDR_W         = 22;
   localparam int  ROWS_4K        = 4096;
   localparam int  ROWS_2K        = 2048;
   localparam int  REF_MS_4K      = 64;
   localparam int  REF_MS_2K      = 32;
   localparam int  REF_CYC_4K     = (CLK_HZ / 1000) * REF_MS_4K / ROWS_4K;
   localparam int  REF_CYC_2K     = (CLK_HZ / 1000) * REF_MS_2K / ROWS_2K;
   localparam int  T_RP_NS        = 40;
   localparam int  T_RAS_NS       = 60;
   localparam int  T_RCD_NS       = 15;
   localparam int  T_CAS_NS       = 15;
   localparam int  CLK_NS         = 50;
   localparam int  RP_CYC         = (T_RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int  RAS_CYC        = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
   localparam int  RCD_CYC        = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
   localparam int  CAS_CYC        = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
   localparam int  CNT_W          = 16;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } req_s;

   typedef struct packed {
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic              oe_n;
      logic [ROW_W-1:0]  addr;
   } pins_s;
endpackage : edo_ctrl_pkg

// ===== src/edo_ctrl.sv
// Controller driving an asynchronous 4M x 4 extended-data-out DRAM
`timescale 1ns/1ps
module edo_ctrl #(
   parameter bit USE_2K      = 1'b0,
   parameter bit USE_COL_FIRST = 1'b1,
   parameter int REF_4K_CYC  = edo_ctrl_pkg::REF_CYC_4K,
   parameter int REF_2K_CYC  = edo_ctrl_pkg::REF_CYC_2K
) (
   // Clock and reset
   input  wire logic                              clk_sys,
   input  wire logic                              reset,
   // Request side
   input  wire logic                              req_valid,
   input  wire edo_ctrl_pkg::req_s                req,
   output logic                                   req_ready,
   output logic                                   rd_valid,
   output logic [edo_ctrl_pkg::DATA_W-1:0]        rd_data,
   // Memory pins
   output edo_ctrl_pkg::pins_s                    pins,
   output logic [edo_ctrl_pkg::DATA_W-1:0]        data_out,
   output logic                                   data_oe_n,
   input  wire logic [edo_ctrl_pkg::DATA_W-1:0]   data_in
);
   localparam int RW = edo_ctrl_pkg::ROW_W;
   localparam int CW = edo_ctrl_pkg::COL_W;
   localparam int DW = edo_ctrl_pkg::DATA_W;
   localparam int NW = edo_ctrl_pkg::CNT_W;
   localparam int REF_CYC = USE_2K ? REF_2K_CYC : REF_4K_CYC;
   // Extra cycle so held read data has reached the last synchroniser stage
   localparam int SYNC_WAIT = 1;

   initial begin
      if (REF_CYC < 16 || REF_CYC >= (1 << NW))
         $error("refresh interval out of range");
   end

   typedef enum logic [3:0] {
      S_IDLE, S_PRE, S_ROW, S_RCD, S_COL, S_HOLD, S_CAP, S_CFR_C, S_CFR_R, S_ROR
   } state_e;

   // Row field of a word address, top pin zero on the 2K part
   function automatic logic [RW-1:0] row_of(input logic [edo_ctrl_pkg::ADDR_W-1:0] a);
      logic [RW-1:0] r;
      r = a[edo_ctrl_pkg::ADDR_W-1:CW];
      if (USE_2K)
         r[RW-1] = 1'b0;
      return r;
   endfunction : row_of

   state_e                 st_q, st_d;
   logic [NW-1:0]          cnt_q, cnt_d, refc_q, refc_d;
   logic                   refp_q, refp_d, open_q, open_d;
   logic [RW-1:0]          orow_q, orow_d, rrow_q, rrow_d;
   edo_ctrl_pkg::req_s     cur_q, cur_d;
   edo_ctrl_pkg::pins_s    pins_d;
   logic [DW-1:0]          dout_d, rdat_d;
   logic                   doe_n_d, rdy_d, rv_d;
   logic [DW-1:0]          din_s1, din_s2, din_s3;

   always_comb begin
      st_d    = st_q;
      cnt_d   = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
      refc_d  = refc_q - 1'b1;
      refp_d  = refp_q;
      open_d  = open_q;
      orow_d  = orow_q;
      rrow_d  = rrow_q;
      cur_d   = cur_q;
      pins_d  = pins;
      dout_d  = data_out;
      doe_n_d = data_oe_n;
      rdy_d   = 1'b0;
      rv_d    = 1'b0;
      rdat_d  = rd_data;
      if (refc_q == '0) begin
         refc_d = NW'(REF_CYC - 1);
         refp_d = 1'b1;
      end
      case (st_q)
         S_IDLE: begin
            rdy_d = !refp_d;
            if (refp_q) begin
               // Close any open row, then refresh
               pins_d.ras_n = 1'b1;
               pins_d.cas_n = 1'b1;
               pins_d.oe_n  = 1'b1;
               doe_n_d      = 1'b1;
               open_d       = 1'b0;
               refp_d       = 1'b0;
               cnt_d        = NW'(edo_ctrl_pkg::RP_CYC);
               pins_d.addr  = rrow_q;
               st_d         = USE_COL_FIRST ? S_CFR_C : S_ROR;
               rdy_d        = 1'b0;
            end else if (req_valid && req_ready) begin
               cur_d = req;
               rdy_d = 1'b0;
               if (open_q && orow_q == row_of(req.addr)) begin
                  st_d = S_COL;
                  pins_d.addr = RW'(req.addr[CW-1:0]);
                  // Steering settles a cycle before the column strobe falls
                  pins_d.we_n = !req.write;
                  pins_d.oe_n = req.write;
                  doe_n_d     = !req.write;
                  dout_d      = req.wdata;
               end else begin
                  pins_d.ras_n = 1'b1;
                  pins_d.cas_n = 1'b1;
                  pins_d.oe_n  = 1'b1;
                  doe_n_d      = 1'b1;
                  open_d       = 1'b0;
                  cnt_d        = NW'(edo_ctrl_pkg::RP_CYC);
                  st_d         = S_PRE;
               end
            end
         end
         S_PRE: if (cnt_q == '0) begin
            pins_d.addr = row_of(cur_q.addr);
            st_d        = S_ROW;
         end
         S_ROW: begin
            pins_d.ras_n = 1'b0;
            open_d       = 1'b1;
            orow_d       = row_of(cur_q.addr);
            cnt_d        = NW'(edo_ctrl_pkg::RCD_CYC);
            st_d         = S_RCD;
         end
         S_RCD: begin
            pins_d.addr = RW'(cur_q.addr[CW-1:0]);
            pins_d.we_n = !cur_q.write;
            pins_d.oe_n = cur_q.write;
            doe_n_d     = !cur_q.write;
            dout_d      = cur_q.wdata;
            if (cnt_q == '0)
               st_d = S_COL;
         end
         S_COL: begin
            pins_d.cas_n = 1'b0;
            cnt_d        = NW'(edo_ctrl_pkg::CAS_CYC);
            st_d         = S_HOLD;
         end
         S_HOLD: if (cnt_q == '0) begin
            pins_d.cas_n = 1'b1;
            cnt_d        = NW'(SYNC_WAIT);
            st_d         = S_CAP;
         end
         S_CAP: if (cnt_q == '0) begin
            // Sample after the column strobe rose; data is still held
            rv_d        = !cur_q.write;
            rdat_d      = din_s3;
            pins_d.we_n = 1'b1;
            pins_d.oe_n = 1'b1;
            doe_n_d     = 1'b1;
            st_d        = S_IDLE;
            rdy_d       = !refp_d;
         end
         S_CFR_C: if (cnt_q == '0) begin
            pins_d.cas_n = 1'b0;
            st_d         = S_CFR_R;
            cnt_d        = NW'(edo_ctrl_pkg::RAS_CYC + 1);
         end
         S_CFR_R: begin
            pins_d.ras_n = 1'b0;
            if (cnt_q == '0) begin
               pins_d.ras_n = 1'b1;
               pins_d.cas_n = 1'b1;
               cnt_d        = NW'(edo_ctrl_pkg::RP_CYC);
               st_d         = S_IDLE;
            end
         end
         S_ROR: begin
            if (cnt_q == '0 && pins.ras_n) begin
               pins_d.ras_n = 1'b0;
               cnt_d        = NW'(edo_ctrl_pkg::RAS_CYC);
            end else if (cnt_q == '0) begin
               pins_d.ras_n = 1'b1;
               rrow_d       = rrow_q + 1'b1;
               if (USE_2K)
                  rrow_d[RW-1] = 1'b0;
               st_d = S_IDLE;
            end
         end
         default: st_d = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      din_s1 <= data_in;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
      if (reset) begin
         st_q      <= S_IDLE;
         cnt_q     <= '0;
         refc_q    <= NW'(REF_CYC - 1);
         refp_q    <= 1'b0;
         open_q    <= 1'b0;
         orow_q    <= '0;
         rrow_q    <= '0;
         cur_q     <= '0;
         pins      <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
         data_out  <= '0;
         data_oe_n <= 1'b1;
         req_ready <= 1'b0;
         rd_valid  <= 1'b0;
         rd_data   <= '0;
      end else begin
         st_q      <= st_d;
         cnt_q     <= cnt_d;
         refc_q    <= refc_d;
         refp_q    <= refp_d;
         open_q    <= open_d;
         orow_q    <= orow_d;
         rrow_q    <= rrow_d;
         cur_q     <= cur_d;
         pins      <= pins_d;
         data_out  <= dout_d;
         data_oe_n <= doe_n_d;
         req_ready <= rdy_d;
         rd_valid  <= rv_d;
         rd_data   <= rdat_d;
      end
   end
endmodule : edo_ctrl

// ===== test/edo_ctrl_checker.sv
// Pin protocol checks for the controller
`timescale 1ns/1ps
module edo_ctrl_checker (
   // Clock and reset
   input wire logic                clk_sys,
   input wire logic                reset,
   // Request side
   input wire logic                req_valid,
   input wire edo_ctrl_pkg::req_s  req,
   input wire logic                req_ready,
   input wire logic                rd_valid,
   input wire logic [3:0]          rd_data,
   // Memory pins
   input wire edo_ctrl_pkg::pins_s pins,
   input wire logic [3:0]          data_out,
   input wire logic                data_oe_n,
   input wire logic [3:0]          data_in
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   property p_row; $fell(pins.ras_n) && pins.cas_n |-> $stable(pins.addr); endproperty
   a_row: assert property (p_row) else $error("row addr");
   property p_col; $fell(pins.cas_n) && !pins.ras_n |-> $stable(pins.addr); endproperty
   a_col: assert property (p_col) else $error("col addr");
   property p_cfr; $fell(pins.ras_n) && !pins.cas_n |-> !$past(pins.cas_n) && data_oe_n;
   endproperty
   a_cfr: assert property (p_cfr) else $error("refresh order");
   property p_idle; pins.ras_n && pins.cas_n |-> data_oe_n; endproperty
   a_idle: assert property (p_idle) else $error("bus driven idle");
   property p_wr; $fell(pins.cas_n) && !pins.ras_n |-> pins.we_n == data_oe_n; endproperty
   a_wr: assert property (p_wr) else $error("write steer");
   property p_rd; rd_valid |-> $past(pins.cas_n, 2) && !$past(pins.cas_n, 3); endproperty
   a_rd: assert property (p_rd) else $error("read sample");
   property p_oe; !pins.oe_n |-> data_oe_n && pins.we_n; endproperty
   a_oe: assert property (p_oe) else $error("contention");
   property p_one; req_valid && req_ready |=> !req_ready [*3]; endproperty
   a_one: assert property (p_one) else $error("second request");
endmodule : edo_ctrl_checker
bind edo_ctrl edo_ctrl_checker i_chk (.*);

// ===== test/edo_mem_model.sv
// Behavioural model of the extended-data-out memory
`timescale 1ns/1ps
module edo_mem_model (
   // Memory pins
   input wire edo_ctrl_pkg::pins_s pins,
   input wire logic [3:0]          data_out,
   input wire logic                data_oe_n,
   // Resolved bus and CAS-before-RAS refresh count
   output logic [3:0]              bus,
   output int                      refs
);
   logic [3:0]  mem [logic [21:0]];
   logic [11:0] row_q;
   logic [3:0]  q_q = 4'h0;
   logic        en_q = 1'b0;
   initial refs = 0;
   always @(negedge pins.ras_n) begin
      if (pins.cas_n) row_q = pins.addr;
      else refs++;
   end
   always @(negedge pins.cas_n) if (!pins.ras_n) begin
      if (!pins.we_n) mem[{row_q, pins.addr[9:0]}] = bus;
      else begin
         q_q = mem[{row_q, pins.addr[9:0]}];
         en_q = 1'b1;
      end
   end
   always @(pins.ras_n or pins.cas_n) if (pins.ras_n && pins.cas_n) en_q = 1'b0;
   assign bus = !data_oe_n ? data_out : (en_q && !pins.oe_n) ? q_q : ~q_q;
endmodule : edo_mem_model

// ===== test/tb_edo_ctrl.sv
// Self-checking bench for the controller
`timescale 1ns/1ps
module tb_edo_ctrl;
   logic                clk_sys;
   logic                reset;
   logic                req_valid;
   edo_ctrl_pkg::req_s  req;
   logic                req_ready;
   logic                rd_valid;
   logic [3:0]          rd_data;
   edo_ctrl_pkg::pins_s pins;
   logic [3:0]          data_out;
   logic                data_oe_n;
   logic [3:0]          bus;
   int                  refs;
   int                  seed;
   int                  errors = 0;
   int                  checks = 0;
   int                  cyc = 0;
   logic [3:0]          shadow [logic [21:0]];
   logic [21:0]         used [$];

   edo_ctrl #(.REF_4K_CYC(64)) i_dut (.clk_sys(clk_sys), .reset(reset), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins),
      .data_out(data_out), .data_oe_n(data_oe_n), .data_in(bus));
   edo_mem_model i_mem (.pins(pins), .data_out(data_out), .data_oe_n(data_oe_n), .bus(bus),
      .refs(refs));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         summarize();
      end
   end

   task automatic cmp4(input logic [3:0] g, input logic [3:0] e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("Error %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp4

   task automatic cmpi(input int g, input int e);
      checks++;
      if (g != e) begin
         errors++;
         $display("Error %0t got %h exp %h", $time, g, e);
      end
   endtask : cmpi

   task automatic op(input logic w, input logic [21:0] a, input logic [3:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 300) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 300) errors++;
      req_valid = 1'b1;
      req = {w, a, d};
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      if (w) begin
         shadow[a] = d;
         used.push_back(a);
      end else begin
         n = 0;
         while (rd_valid !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
         end
         if (n >= 50) errors++;
         cmp4(rd_data, shadow[a]);
      end
   endtask : op

   task automatic summarize();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   initial begin
      logic [21:0] a;
      int k;
      int r0;
      reset = 1'b1;
      req_valid = 1'b0;
      req = '0;
      seed = 70689;
      repeat (5) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      // Corner rows and columns
      op(1'b1, 22'h3fffff, 4'ha);
      op(1'b1, 22'h3ffc00, 4'h5);
      op(1'b1, 22'h0003ff, 4'h3);
      for (int i = 0; i < 3; i++) op(1'b0, used[i], 4'h0);
      // Random traffic, two writes in three to the previous write's row
      for (int i = 0; i < 80; i++) begin
         a = 22'($random(seed));
         if (i % 3 != 0) a[21:10] = used[$][21:10];
         op(1'b1, a, 4'($random(seed)));
         k = $unsigned($random(seed)) % used.size();
         op(1'b0, used[k], 4'h0);
      end
      // Idle refresh cadence, then data must survive
      r0 = refs;
      repeat (640) @(posedge clk_sys);
      #1;
      cmpi(int'(refs - r0 >= 9 && refs - r0 <= 11), 1);
      foreach (used[j]) op(1'b0, used[j], 4'h0);
      summarize();
   end
endmodule : tb_edo_ctrl
